//--- logic/art_pkg.sv
// Package of the converter result and trigger register block.
// Assumes an APB slave with 32-bit data; registers take one aligned word each.
package art_pkg;

   // ==========================================================================
   // Register map (printed offsets are not all multiples of four: indices)
   // ==========================================================================
   localparam logic [7:0] RESULT_LOW_IDX = 8'h78;
   localparam logic [7:0] RESULT_HIGH_IDX = 8'h79;
   localparam logic [7:0] CONTROL_A_IDX = 8'h7a;
   localparam logic [7:0] CONTROL_B_IDX = 8'h7b;
   localparam logic [7:0] FORMAT_IDX = 8'h7c;
   localparam logic [7:0] INPUT_DISABLE_IDX = 8'h7e;

   // ==========================================================================
   // Field positions
   // ==========================================================================
   localparam int CTLA_ENABLE_BIT = 7;
   localparam int CTLA_START_BIT = 6;
   localparam int CTLA_AUTO_BIT = 5;
   localparam int CTLA_DONE_BIT = 4;
   localparam int FORMAT_LEFT_BIT = 5;
   localparam logic [7:0] CTLB_WRITE_MASK = 8'h47;
   localparam logic [7:0] DISABLE_WRITE_MASK = 8'h3f;

   // ==========================================================================
   // Reset values
   // ==========================================================================
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [9:0] RESULT_RESET = 10'h000;
   localparam logic [2:0] FREE_RUNNING = 3'h0;

   typedef enum logic [2:0] {
      ART_SRC_FREE, ART_SRC_COMPARATOR, ART_SRC_EXT_INT0, ART_SRC_T0_CMPA,
      ART_SRC_T0_OVF, ART_SRC_T1_CMPB, ART_SRC_T1_OVF, ART_SRC_T1_CAPTURE
   } art_source_type;

endpackage

//--- logic/art_result_if.sv
// Interface carrying the result latch handshake between top and latch.
// Assumes both ends share the core clock.
`timescale 1ns/1ps
`default_nettype none
interface art_result_if;
   logic done;
   logic [9:0] sample;
   logic low_read;
   logic high_read;
   logic [9:0] held;
   modport latch (input done, input sample, input low_read, input high_read, output held);
   modport ctrl (output done, output sample, output low_read, output high_read, input held);
endinterface
`default_nettype wire

//--- logic/art_result_latch.sv
// Result holding register with the low-then-high read lock.
// Assumes read strobes are single-cycle pulses on the core clock.
`timescale 1ns/1ps
`default_nettype none
module art_result_latch (
   input wire logic clk_i,
   input wire logic rst_n_i,
   art_result_if.latch res
);
   logic locked_q;
   logic [9:0] held_q;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         locked_q <= 1'b0;
      end else if (res.high_read) begin
         locked_q <= 1'b0;
      end else if (res.low_read) begin
         locked_q <= 1'b1; // [RULE_04]
      end
   end

   // A result that finishes while locked is dropped unless the high byte is read in that cycle. One that meets
   // the low byte read in the same cycle is dropped too, or the high byte would come from a newer sample.
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         held_q <= art_pkg::RESULT_RESET; // [RULE_21]
      end else if (res.done && (!locked_q || res.high_read) && !res.low_read) begin
         held_q <= res.sample; // [RULE_01] [RULE_04]
      end
   end

   assign res.held = held_q;
endmodule
`default_nettype wire

//--- logic/art_trigger_edge.sv
// Trigger source selector and rising edge detector.
// Assumes the event flags are already synchronous to the core clock.
`timescale 1ns/1ps
`default_nettype none
module art_trigger_edge (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [7:0] flags_i,
   input wire logic [2:0] select_i,
   output logic edge_o
);
   logic sel_q;
   logic sel_d;

   always_comb begin
      sel_d = flags_i[select_i]; // [RULE_10]
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sel_q <= 1'b0;
      end else begin
         sel_q <= sel_d;
      end
   end

   // Free running never yields an edge, even if the done flag is high.
   assign edge_o = sel_d && !sel_q && (select_i != art_pkg::FREE_RUNNING); // [RULE_07] [RULE_08] [RULE_09]
endmodule
`default_nettype wire

//--- logic/art_top.sv
// Register side of a 10-bit converter: result bytes, trigger, pin disables.
// Assumes an APB master on the core clock and an external converter core.
// The trigger flags and the completion pulse are taken to be on the core clock.
// Only the low byte lane of the bus carries data; the bus never waits.
//
// Notes on behaviour
// [RULE_01] A finished conversion loads its 10-bit result into the result bytes.
// [RULE_02] Right aligned: low byte bits 7..0, high byte bits 9..8, zeros above.
// [RULE_03] Left aligned: high byte bits 9..2, low byte bits 1..0 at top.
// [RULE_04] Reading the low byte freezes both bytes until the high byte is read.
// [RULE_05] Software reads low then high, except left aligned eight-bit use.
// [RULE_06] The trigger select only matters while auto trigger is enabled.
// [RULE_07] Auto trigger starts a conversion on each rising edge of the selected flag.
// [RULE_08] Switching select from a low flag to a high one is an edge.
// [RULE_09] Switching to free running never makes a trigger event.
// [RULE_10] Codes 0..7: free, comparator, ext int 0, T0A, T0 ovf, T1B, T1 ovf, T1 capture.
// [RULE_11] Software writes zeros to control B bits 7 and 5..3.
// [RULE_12] Each of six disable bits turns off its pin's digital input buffer.
// [RULE_13] A disabled pin's port value reads zero.
// [RULE_14] Software should disable inputs on pins used only for analog.
// [RULE_15] Channels 6 and 7 have no disable bit.
// [RULE_16] Software writes zeros to disable bits 7 and 6, which read zero.
// [RULE_17] Setting auto trigger enable allows edge-triggered starts.
// [RULE_18] Changing alignment changes the presented bytes at once.
// [RULE_19] Done flag sets when the result is updated; writing one clears it.
// [RULE_20] Free running: one start write launches continuous conversion.
// [RULE_21] Result, trigger and disable bits clear on reset.
//
// The APB register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module art_top (
   input wire logic CORE_CLK_I,
   input wire logic RSTN_I,
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic PWRITE_I,
   input wire logic [11:0] PADDR_I,
   input wire logic [31:0] PWDATA_I,
   input wire logic [3:0] PSTRB_I,
   output logic [31:0] PRDATA_O,
   output logic PREADY_O,
   output logic PSLVERR_O,
   input wire logic CONV_DONE_I,
   input wire logic [9:0] CONV_RESULT_I,
   input wire logic [6:0] TRIGGER_FLAGS_I,
   input wire logic [5:0] PIN_RAW_I,
   output logic [5:0] PIN_VALUE_O,
   output logic [5:0] PIN_BUFFER_OFF_O,
   output logic CONV_START_O,
   output logic CONVERTER_ENABLE_O,
   output logic COMPARATOR_MUX_ENABLE_O
);
   // ==========================================================================
   // Bus decode
   // ==========================================================================
   logic access;
   logic wr;
   logic rd;
   logic aligned;
   logic [7:0] idx;
   logic [7:0] wbyte;
   logic hit;

   assign aligned = (PADDR_I[1:0] == 2'h0);
   assign idx = PADDR_I[9:2];
   assign access = PSEL_I && PENABLE_I;
   assign wr = access && PWRITE_I && PSTRB_I[0];
   assign rd = access && !PWRITE_I;
   assign wbyte = PWDATA_I[7:0];
   assign hit = aligned && (PADDR_I[11:10] == 2'h0) &&
      (idx == art_pkg::RESULT_LOW_IDX || idx == art_pkg::RESULT_HIGH_IDX ||
       idx == art_pkg::CONTROL_A_IDX || idx == art_pkg::CONTROL_B_IDX ||
       idx == art_pkg::FORMAT_IDX || idx == art_pkg::INPUT_DISABLE_IDX);
   // Zero wait states: every register answers in its first access cycle.
   assign PREADY_O = 1'b1;
   assign PSLVERR_O = access && !hit;

   // ==========================================================================
   // Register strobes
   // ==========================================================================
   // One strobe per register keeps each update block down to its own condition.
   logic wr_ctla;
   logic wr_ctlb;
   logic wr_fmt;
   logic wr_dis;
   logic rd_low;
   logic rd_high;
   logic clr_done;

   assign wr_ctla = wr && hit && idx == art_pkg::CONTROL_A_IDX;
   assign wr_ctlb = wr && hit && idx == art_pkg::CONTROL_B_IDX;
   assign wr_fmt = wr && hit && idx == art_pkg::FORMAT_IDX;
   assign wr_dis = wr && hit && idx == art_pkg::INPUT_DISABLE_IDX;
   assign rd_low = rd && hit && idx == art_pkg::RESULT_LOW_IDX;
   assign rd_high = rd && hit && idx == art_pkg::RESULT_HIGH_IDX;
   assign clr_done = wr_ctla && wbyte[art_pkg::CTLA_DONE_BIT];

   // ==========================================================================
   // Control registers
   // ==========================================================================
   logic enable_q;
   logic start_q;
   logic auto_q;
   logic done_q;
   logic left_q;
   logic [7:0] ctlb_q;
   logic [5:0] disable_q;
   logic trig_edge;
   logic busy_q;
   logic conv_take;

   always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         enable_q <= 1'b0;
      end else if (wr_ctla) begin
         enable_q <= wbyte[art_pkg::CTLA_ENABLE_BIT];
      end
   end

   always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         auto_q <= 1'b0;
      end else if (wr_ctla) begin
         auto_q <= wbyte[art_pkg::CTLA_AUTO_BIT]; // [RULE_17]
      end
   end

   always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         left_q <= 1'b0;
      end else if (wr_fmt) begin
         left_q <= wbyte[art_pkg::FORMAT_LEFT_BIT];
      end
   end

   always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         ctlb_q <= art_pkg::REG_RESET; // [RULE_21]
      end else if (wr_ctlb) begin
         ctlb_q <= wbyte & art_pkg::CTLB_WRITE_MASK; // [RULE_11]
      end
   end

   always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         disable_q <= 6'h00; // [RULE_21]
      end else if (wr_dis) begin
         disable_q <= wbyte[5:0]; // [RULE_12] [RULE_15] [RULE_16]
      end
   end

   // A finished conversion only counts while the converter is switched on.
   assign conv_take = CONV_DONE_I && enable_q;

   // Set wins over a simultaneous write-one clear so no completion is lost.
   always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         done_q <= 1'b0;
      end else if (conv_take) begin
         done_q <= 1'b1; // [RULE_19]
      end else if (clr_done) begin
         done_q <= 1'b0; // [RULE_19]
      end
   end

   // ==========================================================================
   // Start logic
   // ==========================================================================
   logic sw_start;
   logic fire;
   art_pkg::art_source_type trig_src;

   assign trig_src = art_pkg::art_source_type'(ctlb_q[2:0]);
   assign sw_start = wr_ctla && wbyte[art_pkg::CTLA_START_BIT];
   // Free running retriggers off each completion; other sources use their edges.
   assign fire = enable_q && !busy_q && (sw_start || start_q ||
      (auto_q && trig_edge)); // [RULE_06] [RULE_20]

   always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         start_q <= 1'b0;
      end else if (!enable_q) begin
         start_q <= 1'b0;
      end else if (auto_q && trig_src == art_pkg::ART_SRC_FREE && busy_q && CONV_DONE_I) begin
         start_q <= 1'b1; // [RULE_20]
      end else if (fire) begin
         start_q <= 1'b0;
      end
   end

   always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         busy_q <= 1'b0;
      // Switching the converter off mid-conversion abandons the conversion.
      end else if (!enable_q || CONV_DONE_I) begin
         busy_q <= 1'b0;
      end else if (fire) begin
         busy_q <= 1'b1;
      end
   end

   always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         CONV_START_O <= 1'b0;
      end else begin
         // Registered so that the start stands one whole cycle at the converter.
         CONV_START_O <= fire;
      end
   end

   // ==========================================================================
   // Trigger edge
   // ==========================================================================
   // A flag edge that arrives while a conversion runs is not remembered.
   art_trigger_edge u_edge (
      .clk_i(CORE_CLK_I),
      .rst_n_i(RSTN_I),
      .flags_i({TRIGGER_FLAGS_I, done_q}),
      .select_i(ctlb_q[2:0]),
      .edge_o(trig_edge)
   );

   // ==========================================================================
   // Result latch
   // ==========================================================================
   art_result_if res_if ();

   // Reads of the result bytes steer the lock; the bytes come back combinationally.
   assign res_if.done = conv_take;
   assign res_if.sample = CONV_RESULT_I;
   assign res_if.low_read = rd_low;
   assign res_if.high_read = rd_high;

   art_result_latch u_latch (
      .clk_i(CORE_CLK_I),
      .rst_n_i(RSTN_I),
      .res(res_if)
   );

   logic [7:0] low_view;
   logic [7:0] high_view;

   // Alignment is applied at read time so it takes effect at once.
   always_comb begin
      if (left_q) begin
         high_view = res_if.held[9:2]; // [RULE_03] [RULE_18]
         low_view = {res_if.held[1:0], 6'h00}; // [RULE_03]
      end else begin
         high_view = {6'h00, res_if.held[9:8]}; // [RULE_02] [RULE_18]
         low_view = res_if.held[7:0]; // [RULE_02]
      end
   end

   // ==========================================================================
   // Pins
   // ==========================================================================
   // The pins are not on the core clock, so two flops stand ahead of any logic.
   logic [5:0] pin_meta_q;
   logic [5:0] pin_sync_q;

   always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         pin_meta_q <= 6'h00;
         pin_sync_q <= 6'h00;
      end else begin
         pin_meta_q <= PIN_RAW_I;
         pin_sync_q <= pin_meta_q;
      end
   end

   always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         PIN_VALUE_O <= 6'h00;
      end else begin
         PIN_VALUE_O <= pin_sync_q & ~disable_q; // [RULE_13]
      end
   end

   assign PIN_BUFFER_OFF_O = disable_q; // [RULE_12]
   assign CONVERTER_ENABLE_O = enable_q;
   assign COMPARATOR_MUX_ENABLE_O = ctlb_q[6];

   // ==========================================================================
   // Read data
   // ==========================================================================
   // Control A bits 3..0 are not implemented and read as zero.
   logic [7:0] rbyte;

   always_comb begin
      rbyte = 8'h00;
      if (hit) begin
         unique case (idx)
            art_pkg::RESULT_LOW_IDX: rbyte = low_view;
            art_pkg::RESULT_HIGH_IDX: rbyte = high_view;
            art_pkg::CONTROL_A_IDX: rbyte = {enable_q, busy_q | start_q, auto_q, done_q, 4'h0};
            art_pkg::CONTROL_B_IDX: rbyte = ctlb_q;
            art_pkg::FORMAT_IDX: rbyte = {2'h0, left_q, 5'h00};
            art_pkg::INPUT_DISABLE_IDX: rbyte = {2'h0, disable_q};
            default: rbyte = 8'h00;
         endcase
      end
   end

   assign PRDATA_O = {24'h000000, rbyte};
endmodule
`default_nettype wire

//--- testbench/art_top_chk.sv
// Checker of the converter register block, bound to the top module ports.
// Assumes APB transfers keep their setup and access phases.
`timescale 1ns/1ps
`default_nettype none
module art_top_chk (
   input wire logic CORE_CLK_I,
   input wire logic RSTN_I,
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic PWRITE_I,
   input wire logic [11:0] PADDR_I,
   input wire logic [31:0] PWDATA_I,
   input wire logic [3:0] PSTRB_I,
   input wire logic [31:0] PRDATA_O,
   input wire logic CONV_DONE_I,
   input wire logic [6:0] TRIGGER_FLAGS_I,
   input wire logic [5:0] PIN_VALUE_O,
   input wire logic [5:0] PIN_BUFFER_OFF_O,
   input wire logic CONV_START_O,
   input wire logic CONVERTER_ENABLE_O
);
   // ==========================================================================
   // Shadow of the control bits and busy state, rebuilt from the bus and converter traffic
   // ==========================================================================
   logic wr, rd, flag, left_q, auto_q, busy_q;
   logic [2:0] sel_q;
   assign wr = PSEL_I && PENABLE_I && PWRITE_I && PSTRB_I[0];
   assign rd = PSEL_I && PENABLE_I && !PWRITE_I;
   assign flag = (sel_q == 3'h0) ? 1'b0 : TRIGGER_FLAGS_I[sel_q - 3'h1];
   always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         left_q <= 1'b0;
         auto_q <= 1'b0;
         sel_q <= 3'h0;
         busy_q <= 1'b0;
      end else begin
         if (wr && PADDR_I == 12'h1f0) left_q <= PWDATA_I[5];
         if (wr && PADDR_I == 12'h1e8) auto_q <= PWDATA_I[5];
         if (wr && PADDR_I == 12'h1ec) sel_q <= PWDATA_I[2:0];
         if (CONV_START_O) busy_q <= 1'b1;
         else if (CONV_DONE_I) busy_q <= 1'b0;
      end
   end
   default clocking cb @(posedge CORE_CLK_I); endclocking
   default disable iff (!RSTN_I);
   // ==========================================================================
   // Properties
   // ==========================================================================
   hi_zero_a: assert property (rd && PADDR_I == 12'h1e4 && !left_q |-> PRDATA_O[7:2] == 6'h00)
      else $error("high byte upper bits not zero");
   lo_zero_a: assert property (rd && PADDR_I == 12'h1e0 && left_q |-> PRDATA_O[5:0] == 6'h00)
      else $error("low byte lower bits not zero");
   dis_top_a: assert property (rd && PADDR_I == 12'h1f8 |-> PRDATA_O[7:6] == 2'h0)
      else $error("disable reserved bits not zero");
   buf_off_a: assert property (wr && PADDR_I == 12'h1f8 |=> PIN_BUFFER_OFF_O == $past(PWDATA_I[5:0]))
      else $error("buffer off bits differ from write");
   // The port value is registered, so a fresh disable gets one cycle of grace.
   pin_zero_a: assert property ((PIN_VALUE_O & PIN_BUFFER_OFF_O & $past(PIN_BUFFER_OFF_O)) == 6'h00)
      else $error("disabled pin reads one");
   start_pulse_a: assert property (CONV_START_O |=> !CONV_START_O)
      else $error("start longer than one cycle");
   trig_edge_a: assert property (auto_q && CONVERTER_ENABLE_O && !busy_q && !CONV_START_O && $rose(flag) |=> CONV_START_O)
      else $error("trigger edge gave no start");
   start_en_a: assert property (CONV_START_O |-> $past(CONVERTER_ENABLE_O))
      else $error("start while converter off");
   rst_clear_a: assert property ($rose(RSTN_I) |-> PIN_BUFFER_OFF_O == 6'h00 && !CONV_START_O)
      else $error("outputs not clear after reset");
   cov_lock_c: cover property (rd && PADDR_I == 12'h1e0);
   cov_left_c: cover property (wr && PADDR_I == 12'h1f0 && PWDATA_I[5]);
   cov_trig_c: cover property (auto_q && $rose(CONV_START_O));
endmodule
bind art_top art_top_chk u_chk (.CORE_CLK_I, .RSTN_I, .PSEL_I, .PENABLE_I, .PWRITE_I, .PADDR_I, .PWDATA_I,
   .PSTRB_I, .PRDATA_O, .CONV_DONE_I, .TRIGGER_FLAGS_I, .PIN_VALUE_O, .PIN_BUFFER_OFF_O, .CONV_START_O,
   .CONVERTER_ENABLE_O);
`default_nettype wire

//--- testbench/tb.sv
// Self-checking bench of the converter register block.
// Assumes zero wait APB answers and a start pulse one cycle after its cause.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin miscompares++; \
   $display("unexpected at %0t got %h expected %h", $time, a, b); end end
module tb;
   localparam logic [11:0] LO = {2'h0, art_pkg::RESULT_LOW_IDX, 2'h0};
   localparam logic [11:0] HI = {2'h0, art_pkg::RESULT_HIGH_IDX, 2'h0};
   localparam logic [11:0] CA = {2'h0, art_pkg::CONTROL_A_IDX, 2'h0};
   localparam logic [11:0] CB = {2'h0, art_pkg::CONTROL_B_IDX, 2'h0};
   localparam logic [11:0] FM = {2'h0, art_pkg::FORMAT_IDX, 2'h0};
   localparam logic [11:0] DI = {2'h0, art_pkg::INPUT_DISABLE_IDX, 2'h0};
   logic clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, conv_done = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata;
   logic [9:0] conv_result = 10'h000;
   logic [3:0] pstrb = 4'hf;
   logic [6:0] flags = 7'h00;
   logic [5:0] pin_raw = 6'h00, pin_value, buf_off;
   logic pready, pslverr, conv_start, conv_en, cmp_mux, err;
   logic [7:0] rdata;
   int compares = 0, miscompares = 0, starts = 0, cycles = 0;
   art_top u_dut (.CORE_CLK_I(clk), .RSTN_I(rstn), .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
      .PADDR_I(paddr), .PWDATA_I(pwdata), .PSTRB_I(pstrb), .PRDATA_O(prdata), .PREADY_O(pready),
      .PSLVERR_O(pslverr), .CONV_DONE_I(conv_done), .CONV_RESULT_I(conv_result), .TRIGGER_FLAGS_I(flags),
      .PIN_RAW_I(pin_raw), .PIN_VALUE_O(pin_value), .PIN_BUFFER_OFF_O(buf_off), .CONV_START_O(conv_start),
      .CONVERTER_ENABLE_O(conv_en), .COMPARATOR_MUX_ENABLE_O(cmp_mux));
   initial forever #2 clk = ~clk;
   // ==========================================================================
   // Bus and converter tasks
   // ==========================================================================
   task automatic apb(input logic [11:0] a, input logic w, input logic [7:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      rdata = prdata[7:0];
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd_chk(input logic [11:0] a, input logic [7:0] e);
      apb(a, 1'b0, 8'h00);
      `CHK(rdata, e)
   endtask
   // The result bus is inverted after the pulse so a stale value cannot pass.
   task automatic conv(input logic [9:0] v);
      @(posedge clk);
      conv_done <= 1'b1;
      conv_result <= v;
      @(posedge clk);
      conv_done <= 1'b0;
      conv_result <= ~v;
   endtask
   task automatic fire(input logic [2:0] c, input logic [6:0] f, input int inc);
      int n;
      n = starts;
      flags <= f;
      apb(CB, 1'b1, {5'h0, c});
      repeat (4) @(posedge clk);
      `CHK(starts, n + inc)
      flags <= 7'h00;
      if (inc > 0) conv(10'h000);
   endtask
   // ==========================================================================
   // Scenarios
   // ==========================================================================
   task automatic t_reset;
      logic [11:0] regs [6] = '{LO, HI, CA, CB, FM, DI};
      foreach (regs[i]) rd_chk(regs[i], 8'h00);
      `CHK(buf_off, 6'h00)
      apb(12'h1f4, 1'b1, 8'hff);
      `CHK(err, 1'b1)
      pstrb <= 4'h0;
      apb(DI, 1'b1, 8'h3f);
      pstrb <= 4'hf;
      rd_chk(DI, 8'h00);
      apb(CB, 1'b1, 8'h40);
      rd_chk(CB, 8'h40);
      `CHK(cmp_mux, 1'b1)
      apb(CB, 1'b1, 8'h00);
   endtask
   task automatic t_align;
      apb(CA, 1'b1, 8'h80);
      conv(10'h2a5);
      `CHK(conv_en, 1'b1)
      rd_chk(LO, 8'ha5);
      rd_chk(HI, 8'h02);
      apb(FM, 1'b1, 8'h20);
      rd_chk(LO, 8'h40);
      rd_chk(HI, 8'ha9);
      apb(CA, 1'b0, 8'h00);
      `CHK(rdata[7:4], 4'h9)
      apb(CA, 1'b1, 8'h90);
      apb(CA, 1'b0, 8'h00);
      `CHK(rdata[7:4], 4'h8)
   endtask
   task automatic t_lock;
      apb(FM, 1'b1, 8'h00);
      rd_chk(LO, 8'ha5);
      conv(10'h15a);
      rd_chk(HI, 8'h02);
      conv(10'h15a);
      rd_chk(LO, 8'h5a);
      rd_chk(HI, 8'h01);
   endtask
   task automatic t_pins;
      pin_raw <= 6'h3f;
      apb(DI, 1'b1, 8'h3f);
      rd_chk(DI, 8'h3f);
      `CHK(buf_off, 6'h3f)
      repeat (4) @(posedge clk);
      `CHK(pin_value, 6'h00)
      apb(DI, 1'b1, 8'h15);
      repeat (4) @(posedge clk);
      `CHK(pin_value, 6'h2a)
   endtask
   task automatic t_trig;
      for (int a = 0; a < 2; a++) begin
         apb(CA, 1'b1, (a > 0) ? 8'ha0 : 8'h80);
         for (int c = 1; c < 8; c++) fire(3'(c), 7'h01 << (c - 1), a);
      end
      fire(3'h7, 7'h40, 1);
      fire(3'h0, 7'h00, 0);
   endtask
   task automatic t_free;
      int n;
      n = starts;
      apb(CA, 1'b1, 8'he0);
      repeat (3) @(posedge clk);
      `CHK(starts, n + 1)
      conv(10'h3ff);
      repeat (3) @(posedge clk);
      `CHK(starts, n + 2)
      apb(CA, 1'b1, 8'h00);
   endtask
   task automatic complete_run;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cycles++;
      if (conv_start === 1'b1) starts++;
      if (cycles == 20000) begin
         miscompares++;
         complete_run();
      end
   end
   initial begin
      repeat (8) @(posedge clk);
      rstn <= 1'b1;
      t_reset();
      t_align();
      t_lock();
      t_pins();
      t_trig();
      t_free();
      complete_run();
   end
endmodule
`default_nettype wire
